// file: inc/boost_cfg_map.svh
/*
 Offsets, reset values and constants of the converter configuration target.
 Assumes inclusion by bare name from the design file.
*/
`ifndef BOOST_CFG_MAP_SVH
`define BOOST_CFG_MAP_SVH
`define TARGET_ADDR      7'h60
`define REG_CFG_A_OFS    8'h00
`define REG_CFG_B_OFS    8'h01
`define CFG_A_RESET      8'h00
`define CFG_B_RESET      8'h00
`define HS_CODE_PREFIX   5'h01
`define BIT_CNT_LAST     4'h8
`endif

// file: inc/boost_cfg_pkg.sv
/*
 Types of the converter configuration target.
 Assumes nothing of its surroundings.
*/
`default_nettype none
package boost_cfg_pkg;
   typedef enum logic [5:0] {
      st_idle = 6'h01,
      st_addr = 6'h02,
      st_ack  = 6'h04,
      st_wrx  = 6'h08,
      st_tx   = 6'h10,
      st_rack = 6'h20
   } tgt_state_t;
endpackage : boost_cfg_pkg
`default_nettype wire

// file: hw/boost_config_i2c_target.sv
/*
 I2C target holding the two converter configuration registers.
 Assumes SCL, SDA and enable arrive asynchronous to sys_clk; SCL well below a
 quarter of sys_clk; the bench resolves the open-drain SDA from sda_oe.
*/
// Overview of operation
// - Answer only seven-bit address 0x60; other addresses get no acknowledge.
// - Direction bit 0 writes, 1 reads; receiver acknowledges by pulling SDA low.
// - High-speed mode survives repeated starts between commands.
// - A stop condition leaves high-speed mode.
// - First write byte selects register, next byte is stored there.
// - Rising edge of enable restores both registers to defaults.
`timescale 1ns/10ps
`default_nettype none
`include "boost_cfg_map.svh"
module boost_config_i2c_target (
   input  wire logic       sys_clk,
   input  wire logic       resetn,
   input  wire logic       scl_in,
   input  wire logic       sda_in,
   input  wire logic       chip_en,
   output logic            sda_out,
   output logic            sda_oe,
   output logic [7:0]      cfg_a,
   output logic [7:0]      cfg_b,
   output logic            hs_mode
);
   import boost_cfg_pkg::*;

   // ****************************************
   // Input synchronisers
   // ****************************************
   logic [1:0] scl_s_q, sda_s_q, en_s_q;
   logic       scl_p_q, sda_p_q, en_p_q;
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         scl_s_q <= 2'h3;
         sda_s_q <= 2'h3;
         en_s_q  <= 2'h0;
         scl_p_q <= 1'b1;
         sda_p_q <= 1'b1;
         en_p_q  <= 1'b0;
      end else begin
         scl_s_q <= {scl_s_q[0], scl_in};
         sda_s_q <= {sda_s_q[0], sda_in};
         en_s_q  <= {en_s_q[0], chip_en};
         scl_p_q <= scl_s_q[1];
         sda_p_q <= sda_s_q[1];
         en_p_q  <= en_s_q[1];
      end
   end
   logic scl, sda, scl_rise, scl_fall, start_det, stop_det, en_rise;
   assign scl       = scl_s_q[1];
   assign sda       = sda_s_q[1];
   assign scl_rise  = scl & ~scl_p_q;
   assign scl_fall  = ~scl & scl_p_q;
   assign start_det = scl & scl_p_q & sda_p_q & ~sda;
   assign stop_det  = scl & scl_p_q & ~sda_p_q & sda;
   assign en_rise   = en_s_q[1] & ~en_p_q;

   // ****************************************
   // Protocol engine
   // ****************************************
   tgt_state_t state_q, state_d;
   logic [7:0] shf_q, shf_d, ptr_q, ptr_d, a_q, a_d, b_q, b_d;
   logic [3:0] cnt_q, cnt_d;
   logic       rd_q, rd_d, ptr_ph_q, ptr_ph_d, ack_q, ack_d;
   logic       oe_q, oe_d, hs_q, hs_d;
   logic [7:0] sel_reg;
   assign sel_reg = (ptr_q == `REG_CFG_B_OFS) ? b_q : a_q;

   always_comb begin
      state_d  = state_q;
      shf_d    = shf_q;
      ptr_d    = ptr_q;
      a_d      = a_q;
      b_d      = b_q;
      cnt_d    = cnt_q;
      rd_d     = rd_q;
      ptr_ph_d = ptr_ph_q;
      ack_d    = ack_q;
      oe_d     = oe_q;
      hs_d     = hs_q;
      if (stop_det) begin
         state_d = st_idle;
         oe_d    = 1'b0;
         hs_d    = 1'b0;
      end else if (start_det) begin
         state_d = st_addr;
         cnt_d   = 4'h0;
         oe_d    = 1'b0;
      end else begin
         case (state_q)
            st_idle: oe_d = 1'b0;
            st_addr, st_wrx: begin
               if (scl_rise) begin
                  shf_d = {shf_q[6:0], sda};
                  cnt_d = cnt_q + 4'h1;
               end
               if (scl_fall && cnt_q == `BIT_CNT_LAST) begin
                  if (state_q == st_addr) begin
                     if (shf_q[7:1] == `TARGET_ADDR) begin
                        ack_d    = 1'b1;
                        rd_d     = shf_q[0];
                        ptr_ph_d = 1'b1;
                     end else begin
                        ack_d = 1'b0;
                        if (shf_q[7:3] == `HS_CODE_PREFIX)
                           hs_d = 1'b1;
                     end
                  end else begin
                     ack_d = 1'b1;
                     if (ptr_ph_q) begin
                        ptr_d    = shf_q;
                        ptr_ph_d = 1'b0;
                     end else if (ptr_q == `REG_CFG_A_OFS) begin
                        a_d = shf_q;
                     end else if (ptr_q == `REG_CFG_B_OFS) begin
                        b_d = shf_q;
                     end
                  end
                  oe_d    = ack_d;
                  state_d = st_ack;
               end
            end
            st_ack: begin
               if (scl_fall) begin
                  cnt_d = 4'h0;
                  if (!ack_q) begin
                     state_d = st_idle;
                     oe_d    = 1'b0;
                  end else if (rd_q) begin
                     shf_d   = {sel_reg[6:0], 1'b0};
                     oe_d    = ~sel_reg[7];
                     cnt_d   = 4'h1;
                     state_d = st_tx;
                  end else begin
                     oe_d    = 1'b0;
                     state_d = st_wrx;
                  end
               end
            end
            st_tx: begin
               if (scl_fall) begin
                  if (cnt_q == `BIT_CNT_LAST) begin
                     oe_d    = 1'b0;
                     state_d = st_rack;
                  end else begin
                     oe_d  = ~shf_q[7];
                     shf_d = {shf_q[6:0], 1'b0};
                     cnt_d = cnt_q + 4'h1;
                  end
               end
            end
            st_rack: begin
               if (scl_rise)
                  ack_d = ~sda;
               if (scl_fall) begin
                  if (ack_q) begin
                     shf_d   = {sel_reg[6:0], 1'b0};
                     oe_d    = ~sel_reg[7];
                     cnt_d   = 4'h1;
                     state_d = st_tx;
                  end else begin
                     state_d = st_idle;
                     oe_d    = 1'b0;
                  end
               end
            end
            default: begin
               state_d = st_idle;
               oe_d    = 1'b0;
            end
         endcase
      end
      // Enable edge wins over a simultaneous write
      if (en_rise) begin
         a_d = `CFG_A_RESET;
         b_d = `CFG_B_RESET;
      end
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         state_q  <= st_idle;
         shf_q    <= 8'h00;
         ptr_q    <= 8'h00;
         a_q      <= `CFG_A_RESET;
         b_q      <= `CFG_B_RESET;
         cnt_q    <= 4'h0;
         rd_q     <= 1'b0;
         ptr_ph_q <= 1'b0;
         ack_q    <= 1'b0;
         oe_q     <= 1'b0;
         hs_q     <= 1'b0;
      end else begin
         state_q  <= state_d;
         shf_q    <= shf_d;
         ptr_q    <= ptr_d;
         a_q      <= a_d;
         b_q      <= b_d;
         cnt_q    <= cnt_d;
         rd_q     <= rd_d;
         ptr_ph_q <= ptr_ph_d;
         ack_q    <= ack_d;
         oe_q     <= oe_d;
         hs_q     <= hs_d;
      end
   end

   // Open drain: data out is always low, only the enable moves
   assign sda_out = 1'b0;
   assign sda_oe  = oe_q;
   assign cfg_a   = a_q;
   assign cfg_b   = b_q;
   assign hs_mode = hs_q;

   // ****************************************
   // Checks
   // ****************************************
   a_stop_hs_off: assert property (@(posedge sys_clk) disable iff (!resetn)
      stop_det |=> !hs_q) else $error("high-speed mode kept after stop");
   a_rstart_hs_keep: assert property (@(posedge sys_clk) disable iff (!resetn)
      (start_det && hs_q && !stop_det) |=> hs_q) else $error("high-speed lost on repeated start");
   a_en_defaults: assert property (@(posedge sys_clk) disable iff (!resetn)
      en_rise |=> (a_q == `CFG_A_RESET && b_q == `CFG_B_RESET)) else $error("defaults not restored");
   a_addr_ack: assert property (@(posedge sys_clk) disable iff (!resetn)
      (state_q == st_addr && scl_fall && cnt_q == `BIT_CNT_LAST && !start_det && !stop_det)
      |=> (oe_q == ($past(shf_q[7:1]) == `TARGET_ADDR))) else $error("address acknowledge wrong");
   a_hs_entry: assert property (@(posedge sys_clk) disable iff (!resetn)
      (state_q == st_addr && scl_fall && cnt_q == `BIT_CNT_LAST && shf_q[7:3] == `HS_CODE_PREFIX
       && !start_det && !stop_det) |=> (hs_q && !oe_q)) else $error("master code not handled");
   a_write_store: assert property (@(posedge sys_clk) disable iff (!resetn)
      (state_q == st_wrx && scl_fall && cnt_q == `BIT_CNT_LAST && !ptr_ph_q && ptr_q == `REG_CFG_A_OFS
       && !start_det && !stop_det && !en_rise) |=> (a_q == $past(shf_q))) else $error("write not stored");
   a_tx_msb: assert property (@(posedge sys_clk) disable iff (!resetn)
      (state_q == st_ack && rd_q && ack_q && scl_fall && !start_det && !stop_det)
      |=> (oe_q == !$past(sel_reg[7]))) else $error("first read bit not msb");
   a_ptr_load: assert property (@(posedge sys_clk) disable iff (!resetn)
      (state_q == st_wrx && scl_fall && cnt_q == `BIT_CNT_LAST && ptr_ph_q && !start_det && !stop_det)
      |=> (ptr_q == $past(shf_q) && !ptr_ph_q)) else $error("pointer not loaded");
   a_idle_release: assert property (@(posedge sys_clk) disable iff (!resetn)
      state_q == st_idle |-> !oe_q) else $error("SDA held while idle");
endmodule : boost_config_i2c_target
`default_nettype wire

// file: test/i2c_host.sv
/*
 I2C master model: drives SCL, pulls SDA low, keeps SCL still between frames.
 Assumes the bench resolves SDA with a pull-up and feeds it back as sda_wire.
*/
`timescale 1ns/10ps
`default_nettype none
module i2c_host (
   input  wire logic sys_clk,
   input  wire logic sda_wire,
   output var  logic scl,
   output var  logic sda_pull
);
   // ********************************
   // Bit timing: 4 sys_clk low, 4 high
   // ********************************
   initial begin
      scl = 1'b1;
      sda_pull = 1'b0;
   end
   task automatic wait_clk(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask : wait_clk
   // Serves as start and as repeated start
   task automatic start();
      wait_clk(2);
      sda_pull = 1'b0;
      wait_clk(2);
      scl = 1'b1;
      wait_clk(4);
      sda_pull = 1'b1;
      wait_clk(4);
      scl = 1'b0;
   endtask : start
   task automatic stop();
      wait_clk(2);
      sda_pull = 1'b1;
      wait_clk(2);
      scl = 1'b1;
      wait_clk(4);
      sda_pull = 1'b0;
      wait_clk(4);
   endtask : stop
   task automatic bit_io(input logic b, output logic r);
      wait_clk(2);
      sda_pull = ~b;
      wait_clk(2);
      scl = 1'b1;
      wait_clk(4);
      r = sda_wire;
      scl = 1'b0;
   endtask : bit_io
   task automatic wbyte(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) bit_io(d[i], r);
      bit_io(1'b1, r);
      ack = ~r;
   endtask : wbyte
   task automatic rbyte(input logic last, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
      bit_io(last, r);
   endtask : rbyte
endmodule : i2c_host
`default_nettype wire

// file: test/test_boost_config_i2c_target.sv
/*
 Self-checking bench of the configuration target.
 Assumes the master model in i2c_host.sv and a pull-up on SDA.
*/
`timescale 1ns/10ps
`default_nettype none
module test_boost_config_i2c_target;
   import boost_cfg_pkg::*;
   logic       sys_clk = 1'b0;
   logic       resetn = 1'b0;
   logic       chip_en = 1'b1;
   logic       scl, sda_pull, sda_out, sda_oe, hs_mode, k;
   logic [7:0] cfg_a, cfg_b, d;
   wire        sda_wire = !((sda_oe && !sda_out) || sda_pull);
   int         error_cnt = 0;
   int         n_checks = 0;
   always #5 sys_clk = ~sys_clk;
   boost_config_i2c_target i_boost_config_i2c_target (.sys_clk(sys_clk), .resetn(resetn),
      .scl_in(scl), .sda_in(sda_wire), .chip_en(chip_en), .sda_out(sda_out),
      .sda_oe(sda_oe), .cfg_a(cfg_a), .cfg_b(cfg_b), .hs_mode(hs_mode));
   i2c_host i_i2c_host (.sys_clk(sys_clk), .sda_wire(sda_wire), .scl(scl), .sda_pull(sda_pull));
   // ********************************
   // Shared tasks
   // ********************************
   task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string msg);
      n_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: %s", $time, msg);
      end
   endtask : check
   task automatic wr(input logic [7:0] p, input logic [7:0] v);
      i_i2c_host.start();
      i_i2c_host.wbyte(8'hc0, k);
      check({7'h00, k}, 8'h01, "address ack");
      i_i2c_host.wbyte(p, k);
      check({7'h00, k}, 8'h01, "pointer ack");
      i_i2c_host.wbyte(v, k);
      check({7'h00, k}, 8'h01, "data ack");
   endtask : wr
   task automatic report_and_stop();
      $display("checks %0d, mismatches %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : report_and_stop
   // ********************************
   // Scenarios
   // ********************************
   task automatic t_write();
      check(cfg_a, 8'h00, "cfg_a default");
      wr(8'h00, 8'h1e);
      i_i2c_host.stop();
      check(cfg_a, 8'h1e, "cfg_a written");
      wr(8'h01, 8'ha7);
      i_i2c_host.stop();
      check(cfg_b, 8'ha7, "cfg_b written");
      // Pointer outside the map: acknowledged, data dropped
      wr(8'h02, 8'h55);
      i_i2c_host.stop();
      check(cfg_a, 8'h1e, "cfg_a kept");
      check(cfg_b, 8'ha7, "cfg_b kept");
      i_i2c_host.start();
      i_i2c_host.wbyte(8'hc2, k);
      check({7'h00, k}, 8'h00, "foreign address acked");
      i_i2c_host.stop();
      $display("write test done");
   endtask : t_write
   task automatic t_read();
      i_i2c_host.start();
      i_i2c_host.wbyte(8'hc0, k);
      i_i2c_host.wbyte(8'h01, k);
      i_i2c_host.start();
      i_i2c_host.wbyte(8'hc1, k);
      check({7'h00, k}, 8'h01, "read address ack");
      // Master acknowledge asks for another byte of the same register
      i_i2c_host.rbyte(1'b0, d);
      check(d, 8'ha7, "read data");
      i_i2c_host.rbyte(1'b1, d);
      check(d, 8'ha7, "read data again");
      i_i2c_host.stop();
      $display("read test done");
   endtask : t_read
   task automatic t_fast();
      check({7'h00, hs_mode}, 8'h00, "slow mode at start");
      i_i2c_host.start();
      i_i2c_host.wbyte(8'h0d, k);
      check({7'h00, k}, 8'h00, "master code acked");
      check({7'h00, hs_mode}, 8'h01, "fast mode entry");
      wr(8'h00, 8'h42);
      wr(8'h01, 8'h81);
      check({7'h00, hs_mode}, 8'h01, "fast mode kept");
      check(cfg_a, 8'h42, "fast write a");
      check(cfg_b, 8'h81, "fast write");
      i_i2c_host.stop();
      i_i2c_host.wait_clk(4);
      check({7'h00, hs_mode}, 8'h00, "fast mode left");
      $display("fast mode test done");
   endtask : t_fast
   task automatic t_enable();
      chip_en = 1'b0;
      i_i2c_host.wait_clk(8);
      chip_en = 1'b1;
      i_i2c_host.wait_clk(8);
      check(cfg_a, 8'h00, "cfg_a restored");
      check(cfg_b, 8'h00, "cfg_b restored");
      $display("enable test done");
   endtask : t_enable
   initial begin
      i_i2c_host.wait_clk(2);
      resetn = 1'b1;
      i_i2c_host.wait_clk(4);
      t_write();
      t_read();
      t_fast();
      t_enable();
      report_and_stop();
   end
   initial begin
      #200000;
      error_cnt++;
      report_and_stop();
   end
endmodule : test_boost_config_i2c_target
`default_nettype wire
